/* rtl/dpu_pkg.sv */
// Package for the dual prescaler unit: widths, reset values, power modes.
// Assumes a single clock domain; mode codes are driven by the power manager.
package dpu_pkg;

  // Divider widths
  localparam int unsigned MAIN_WIDTH  = 11;
  localparam int unsigned XTAL_WIDTH  = 5;
  localparam int unsigned XTAL_PREDIV = 8;
  localparam int unsigned PREDIV_BITS = 3;

  // Reset values of both counters and the predivider, and the last predivider count
  localparam logic [MAIN_WIDTH-1:0]  MAIN_RESET_VAL  = 11'h000;
  localparam logic [XTAL_WIDTH-1:0]  XTAL_RESET_VAL  = 5'h00;
  localparam logic [PREDIV_BITS-1:0] PREDIV_RESET_VAL = 3'h0;
  localparam logic [PREDIV_BITS-1:0] PREDIV_LAST     = 3'h7;

  // Power modes of the MCU
  typedef enum logic [2:0] {
    DPU_MODE_ACTIVE,
    DPU_MODE_STANDBY,
    DPU_MODE_SUBACTIVE,
    DPU_MODE_WATCH,
    DPU_MODE_STOP
  } dpu_mode_t;

endpackage : dpu_pkg

/* rtl/dpu_edge_det.sv */
// Rising-edge detector that turns a slow clock level into a one-cycle pulse.
// Assumes the level input is already synchronous to clk_in.
`timescale 1ns/100ps
module dpu_edge_det (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // Level in, pulse out
  input  wire logic level_in,
  output logic      rise_out
);
  import dpu_pkg::*;

  logic level_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      level_q <= 1'b0;
    end else if (clk_en_in) begin
      level_q <= level_in;
    end
  end

  assign rise_out = clk_en_in & level_in & ~level_q;

endmodule // dpu_edge_det

/* rtl/dpu_counter.sv */
// Generic up-counter with tick enable and synchronous clear.
// Assumes tick and clear are single-cycle qualifiers in the clk_in domain.
`timescale 1ns/100ps
module dpu_counter #(
  parameter int unsigned WIDTH = 11
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  // Control
  input  wire logic             tick_in,
  input  wire logic             clear_in,
  // Count
  output logic [WIDTH-1:0]      count_out
);
  import dpu_pkg::*;

  // Refused at elaboration, before any logic is built for it
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("dpu_counter: WIDTH out of range");
  end

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  assign count_d = clear_in ? '0 :
                   tick_in  ? WIDTH'(count_q + 1'b1) : count_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_q <= '0;
    end else if (clk_en_in) begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;

endmodule // dpu_counter

/* rtl/dpu_top.sv */
// Dual prescaler unit: a main divider on the system or subsystem clock tick
// and a crystal divider on the low-speed crystal input divided by eight.
// Assumes all tick and level inputs are synchronous to clk_in; the slow
// clocks arrive as levels or ticks, not as clock ports.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Main divider is an 11-bit up-counter whose stages are divided taps.
// - MCU reset clears main divider to zero; counting resumes from zero.
// - Main divider counts continuously except in reset, stop and watch.
// - Main input: system tick in active/standby, subsystem in subactive.
// - Main divider held stopped in MCU reset, stop and watch modes.
// - Crystal divider is 5-bit, fed by crystal input divided by eight.
// - MCU reset clears crystal divider; afterwards it counts continuously.
// - Software can clear the crystal divider without an MCU reset.
// - Crystal divider stops in reset and stop mode, runs in watch mode.
// - Consumers pick taps via own mode registers; external clocks bypass.
// - Time-base use lets software clear crystal divider with its timer.
module dpu_top
  import dpu_pkg::*;
#(
  parameter int unsigned MAIN_W = MAIN_WIDTH,
  parameter int unsigned XTAL_W = XTAL_WIDTH
) (
  // Clock, reset, enable
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              clk_en_in,
  // Power state and MCU reset
  input  wire dpu_pkg::dpu_mode_t mode_in,
  input  wire logic              mcu_rst_in,
  // Clock sources, as one-cycle ticks of the source clock
  input  wire logic              sys_tick_in,
  input  wire logic              sub_tick_in,
  // Low-speed crystal level, synchronous to clk_in
  input  wire logic              low_speed_crystal_input_in,
  // Software clear of the crystal divider
  input  wire logic              xtal_sw_clr_in,
  // Divider taps
  output logic [MAIN_W-1:0]      main_taps_out,
  output logic [XTAL_W-1:0]      xtal_taps_out,
  // Tick pulses at each crystal divider increment
  output logic                   xtal_tick_out
);

  import dpu_pkg::*;

  // Reset values and taps are sized by the package, so other widths would
  // truncate or pad them silently
  if (MAIN_W != MAIN_WIDTH || XTAL_W != XTAL_WIDTH) begin : g_width_check
    $error("dpu_top: divider widths must match the package");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode helpers

  // Subactive only swaps the main source; stop and watch halt it
  function automatic logic main_halted(input dpu_mode_t mode);
    return (mode == DPU_MODE_STOP) || (mode == DPU_MODE_WATCH);
  endfunction

  // Only stop halts the crystal path, so the time base survives watch mode
  function automatic logic xtal_halted(input dpu_mode_t mode);
    return (mode == DPU_MODE_STOP);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode

  wire main_run;
  wire main_src_tick;
  wire xtal_run;
  wire main_tick;
  wire xtal_edge;
  wire prediv_wrap;
  wire xtal_tick;
  wire xtal_clear;

  // Subactive runs the main divider from the subsystem clock
  assign main_src_tick = (mode_in == DPU_MODE_SUBACTIVE) ? sub_tick_in
                                                          : sys_tick_in;
  // Stop and watch halt the main divider; subactive keeps it running
  assign main_run  = ~mcu_rst_in & ~main_halted(mode_in);
  assign main_tick = main_run & main_src_tick;

  // Watch mode keeps the crystal path alive for the time base
  assign xtal_run  = ~mcu_rst_in & ~xtal_halted(mode_in);

  //////////////////////////////////////////////////////////////////////////////
  // Main divider

  logic [MAIN_W-1:0] main_cnt;

  dpu_counter #(
    .WIDTH (MAIN_W)
  ) u_main (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .tick_in    (main_tick),
    .clear_in   (mcu_rst_in),
    .count_out  (main_cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Crystal path: edge detect, divide by eight, 5-bit counter

  dpu_edge_det u_xedge (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .level_in   (low_speed_crystal_input_in),
    .rise_out   (xtal_edge)
  );

  logic [PREDIV_BITS-1:0] prediv_q;
  logic [PREDIV_BITS-1:0] prediv_d;

  // Clearing the predivider too makes a software clear restart a full period
  assign xtal_clear  = mcu_rst_in | xtal_sw_clr_in;
  assign prediv_wrap = (prediv_q == PREDIV_LAST);
  assign xtal_tick   = xtal_run & xtal_edge & prediv_wrap & ~xtal_sw_clr_in;
  assign prediv_d    = xtal_clear ? PREDIV_RESET_VAL :
                       (xtal_run & xtal_edge) ?
                         PREDIV_BITS'(prediv_q + 1'b1) : prediv_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prediv_q <= PREDIV_RESET_VAL;
    end else if (clk_en_in) begin
      prediv_q <= prediv_d;
    end
  end

  logic [XTAL_W-1:0] xtal_cnt;

  dpu_counter #(
    .WIDTH (XTAL_W)
  ) u_xtal (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .tick_in    (xtal_tick),
    .clear_in   (xtal_clear),
    .count_out  (xtal_cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registered tap outputs; consumers select among them themselves

  logic [MAIN_W-1:0] main_taps_q;
  logic [XTAL_W-1:0] xtal_taps_q;
  logic              xtal_tick_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_taps_q <= MAIN_RESET_VAL;
      xtal_taps_q <= XTAL_RESET_VAL;
      xtal_tick_q <= 1'b0;
    end else if (clk_en_in) begin
      main_taps_q <= main_cnt;
      xtal_taps_q <= xtal_cnt;
      xtal_tick_q <= xtal_tick;
    end
  end

  assign main_taps_out = main_taps_q;
  assign xtal_taps_out = xtal_taps_q;
  assign xtal_tick_out = xtal_tick_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_main_reset_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && mcu_rst_in) |=> (main_cnt == MAIN_RESET_VAL))
    else $error("main divider not cleared by MCU reset");

  chk_main_advance: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && main_tick) |=> (main_cnt == MAIN_W'($past(main_cnt) + 1'b1)))
    else $error("main divider did not advance by one");

  chk_main_halt_mode: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !mcu_rst_in &&
     (mode_in == DPU_MODE_STOP || mode_in == DPU_MODE_WATCH))
    |=> $stable(main_cnt))
    else $error("main divider moved in stop or watch");

  chk_main_sub_src: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !mcu_rst_in && mode_in == DPU_MODE_SUBACTIVE
     && sub_tick_in) |=> (main_cnt != $past(main_cnt)))
    else $error("subsystem tick ignored in subactive");

  chk_main_no_tick: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !mcu_rst_in && mode_in == DPU_MODE_ACTIVE && !sys_tick_in)
    |=> $stable(main_cnt))
    else $error("main divider moved without a tick");

  chk_xtal_sw_clear: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && xtal_sw_clr_in) |=> (xtal_cnt == XTAL_RESET_VAL
                                       && prediv_q == PREDIV_RESET_VAL))
    else $error("crystal divider not cleared by software");

  chk_xtal_stop_hold: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && mode_in == DPU_MODE_STOP && !xtal_clear)
    |=> $stable(xtal_cnt) && $stable(prediv_q))
    else $error("crystal divider moved in stop mode");

  chk_xtal_div_eight: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && xtal_tick) |-> (prediv_q == PREDIV_LAST) ##1
    (xtal_cnt == XTAL_W'($past(xtal_cnt) + 1'b1)))
    else $error("crystal divider not stepped on eighth edge");

  chk_xtal_watch_run: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && mode_in == DPU_MODE_WATCH && !mcu_rst_in
     && !xtal_sw_clr_in && xtal_edge)
    |=> (prediv_q == PREDIV_BITS'($past(prediv_q) + 1'b1)))
    else $error("crystal predivider stalled in watch mode");

  chk_tap_follow: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> (main_taps_q == $past(main_cnt)
                   && xtal_taps_q == $past(xtal_cnt)))
    else $error("tap outputs do not follow counters");

  chk_main_std_src: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !mcu_rst_in && mode_in == DPU_MODE_STANDBY
     && sys_tick_in) |=> (main_cnt != $past(main_cnt)))
    else $error("system tick ignored in standby");

  chk_main_sub_gate: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !mcu_rst_in && mode_in == DPU_MODE_SUBACTIVE
     && !sub_tick_in) |=> $stable(main_cnt))
    else $error("main divider moved without a subsystem tick");

  chk_main_wrap: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && main_tick && (&main_cnt)) |=> (main_cnt == '0))
    else $error("main divider did not wrap to zero");

  chk_main_tap_reset: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && mcu_rst_in) ##1 clk_en_in
    |=> (main_taps_q == MAIN_RESET_VAL))
    else $error("main taps not cleared after MCU reset");

  chk_main_freeze: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !clk_en_in |=> ($stable(main_cnt) && $stable(main_taps_q)))
    else $error("main divider moved while the clock enable was low");

  chk_xtal_reset_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && mcu_rst_in) |=> (xtal_cnt == XTAL_RESET_VAL
                                   && prediv_q == PREDIV_RESET_VAL))
    else $error("crystal divider not cleared by MCU reset");

  chk_xtal_tap_reset: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && mcu_rst_in) ##1 clk_en_in
    |=> (xtal_taps_q == XTAL_RESET_VAL))
    else $error("crystal taps not cleared after MCU reset");

  chk_xtal_clr_taps: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && xtal_sw_clr_in) ##1 clk_en_in
    |=> (xtal_taps_q == XTAL_RESET_VAL))
    else $error("crystal taps not cleared by software");

  chk_xtal_step_only: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !xtal_clear && !xtal_tick) |=> $stable(xtal_cnt))
    else $error("crystal divider moved between eighth edges");

  chk_prediv_edge_only: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !xtal_clear && !xtal_edge) |=> $stable(prediv_q))
    else $error("crystal predivider moved without an edge");

  chk_xtal_watch_step: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && mode_in == DPU_MODE_WATCH && !mcu_rst_in
     && !xtal_sw_clr_in && xtal_edge && prediv_q == PREDIV_LAST)
    |=> (xtal_cnt == XTAL_W'($past(xtal_cnt) + 1'b1)))
    else $error("crystal divider stalled in watch mode");

  chk_xtal_freeze: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !clk_en_in |=> ($stable(xtal_cnt) && $stable(prediv_q)
                    && $stable(xtal_taps_q)))
    else $error("crystal path moved while the clock enable was low");

  chk_tick_follow: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> (xtal_tick_q == $past(xtal_tick)))
    else $error("crystal tick output does not follow the increment");

  chk_tick_single: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && xtal_tick_q) |=> !xtal_tick_q)
    else $error("crystal tick output longer than one cycle");

endmodule // dpu_top

/* tb/dpu_xtal_model.sv */
// Low-speed crystal source model feeding the crystal level input.
// Assumes it is clocked by the bench clock and gated by run_in.
`timescale 1ns/100ps
module dpu_xtal_model (
  // Clock and control
  input  wire logic clk_in,
  input  wire logic run_in,
  input  wire logic slow_in,
  // Crystal level, low while stopped so no stale edge survives
  output logic      level_out
);
  logic [1:0] hold_q;
  initial begin
    level_out = 1'b0;
    hold_q    = 2'h0;
  end
  always @(posedge clk_in) begin
    if (!run_in) begin
      level_out <= 1'b0;
      hold_q    <= 2'h0;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      level_out <= ~level_out;
      hold_q    <= slow_in ? 2'h3 : 2'h0;
    end
  end
endmodule // dpu_xtal_model

/* tb/testbench.sv */
// Self-checking bench for the dual prescaler unit with a reference model.
// Assumes the taps settle within a few cycles once stimulus goes quiet.
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module testbench;
  import dpu_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1;
  logic mcu_rst_in = 1'b0, sys_tick_in = 1'b0, sub_tick_in = 1'b0;
  logic xtal_sw_clr_in = 1'b0, xtal_run = 1'b0, xtal_slow = 1'b0;
  logic low_speed_crystal_input_in, xtal_tick_out, prev_q = 1'b0;
  dpu_mode_t mode_in = DPU_MODE_ACTIVE;
  logic [MAIN_WIDTH-1:0]  main_taps_out, exp_main = '0;
  logic [XTAL_WIDTH-1:0]  xtal_taps_out, exp_xtal = '0;
  logic [PREDIV_BITS-1:0] pre_q = '0;
  logic [15:0] seed = 16'hE435;
  int fails = 0, tests_run = 0, inc_exp = 0, inc_seen = 0;
  always #4 clk_in = ~clk_in;
  dpu_xtal_model u_dpu_xtal_model (.clk_in(clk_in), .run_in(xtal_run),
    .slow_in(xtal_slow), .level_out(low_speed_crystal_input_in));
  dpu_top u_dpu_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .mode_in(mode_in), .mcu_rst_in(mcu_rst_in),
    .sys_tick_in(sys_tick_in), .sub_tick_in(sub_tick_in),
    .low_speed_crystal_input_in(low_speed_crystal_input_in),
    .xtal_sw_clr_in(xtal_sw_clr_in), .main_taps_out(main_taps_out),
    .xtal_taps_out(xtal_taps_out), .xtal_tick_out(xtal_tick_out));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Main source follows the power mode; stop and watch halt it
  function automatic logic main_go(input dpu_mode_t m, input logic st,
                                   input logic sb);
    return ((m == DPU_MODE_ACTIVE || m == DPU_MODE_STANDBY) && st) ||
           (m == DPU_MODE_SUBACTIVE && sb);
  endfunction
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      exp_main <= '0;
      exp_xtal <= '0;
      pre_q    <= '0;
      prev_q   <= 1'b0;
    end else if (clk_en_in) begin
      prev_q <= low_speed_crystal_input_in;
      if (mcu_rst_in) begin
        exp_main <= '0;
        exp_xtal <= '0;
        pre_q    <= '0;
      end else begin
        if (main_go(mode_in, sys_tick_in, sub_tick_in))
          exp_main <= exp_main + 1'b1;
        if (xtal_sw_clr_in) begin
          exp_xtal <= '0;
          pre_q    <= '0;
        end else if (low_speed_crystal_input_in && !prev_q &&
                     mode_in != DPU_MODE_STOP) begin
          pre_q <= pre_q + 1'b1;
          if (pre_q == PREDIV_LAST) begin
            exp_xtal <= exp_xtal + 1'b1;
            inc_exp++;
          end
        end
      end
    end
  end
  always @(posedge clk_in) if (xtal_tick_out === 1'b1) inc_seen++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic run(input int n, input dpu_mode_t m, input logic xr,
                     input logic back);
    repeat (n) begin
      @(posedge clk_in);
      seed = lfsr(seed);
      mode_in     <= m;
      xtal_run    <= xr;
      xtal_slow   <= seed[2];
      sys_tick_in <= back | seed[0];
      sub_tick_in <= back | seed[1];
    end
  endtask
  task automatic quiet_check();
    @(posedge clk_in);
    sys_tick_in    <= 1'b0;
    sub_tick_in    <= 1'b0;
    xtal_run       <= 1'b0;
    mcu_rst_in     <= 1'b0;
    xtal_sw_clr_in <= 1'b0;
    clk_en_in      <= 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("main_taps", exp_main, main_taps_out)
    `CHK("xtal_taps", exp_xtal, xtal_taps_out)
    `CHK("xtal_ticks", inc_exp, inc_seen)
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #160000;
    fails++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    quiet_check();
    for (int m = 0; m < 5; m++) begin
      run(300, dpu_mode_t'(m), 1'b1, 1'b0);
      quiet_check();
    end
    // Back-to-back ticks wrap the 11-bit divider; crystal then runs at random speed in watch
    run(2100, DPU_MODE_ACTIVE, 1'b0, 1'b1);
    run(600, DPU_MODE_WATCH, 1'b1, 1'b0);
    quiet_check();
    run(50, DPU_MODE_STANDBY, 1'b1, 1'b0);
    @(posedge clk_in);
    xtal_run       <= 1'b0;
    xtal_sw_clr_in <= 1'b1;
    run(4, DPU_MODE_STANDBY, 1'b0, 1'b0);
    quiet_check();
    clk_en_in <= 1'b0;
    run(40, DPU_MODE_ACTIVE, 1'b0, 1'b1);
    quiet_check();
    run(80, DPU_MODE_SUBACTIVE, 1'b1, 1'b0);
    @(posedge clk_in);
    xtal_run   <= 1'b0;
    mcu_rst_in <= 1'b1;
    run(5, DPU_MODE_ACTIVE, 1'b0, 1'b1);
    quiet_check();
    run(30, DPU_MODE_ACTIVE, 1'b1, 1'b0);
    quiet_check();
    // Mid-run system reset; inputs go quiet before release so that no
    // stale tick is sampled on the releasing edge
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    run(3, DPU_MODE_SUBACTIVE, 1'b1, 1'b1);
    #1;
    `CHK("rst_main_taps", MAIN_RESET_VAL, main_taps_out)
    `CHK("rst_xtal_taps", XTAL_RESET_VAL, xtal_taps_out)
    `CHK("rst_xtal_tick", 1'b0, xtal_tick_out)
    @(posedge clk_in);
    sys_tick_in <= 1'b0;
    sub_tick_in <= 1'b0;
    xtal_run    <= 1'b0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    run(40, DPU_MODE_STANDBY, 1'b1, 1'b0);
    quiet_check();
    summarize();
  end
endmodule // testbench
